// ---- core/psf_top.sv ----
// status flag bank for timer 1, timer 2, serial and handshake port over AHB-Lite
//
// Behaviour
// - tx_hold_empty set by load in async, shifter empty in sync, reset
// - armed tx_hold_reg write clears tx_hold_empty
// - sync disable with data pending locks transmit
// - strobe fall sets flag; armed port access clears
// - capture edge copies counter, sets capture flag
// - armed capture_reg_hi read clears capture flag
// - compare1 match sets; armed compare1 write clears
// - compare2 match sets; only timer b arms
// - wrap flag set cycle after counter top
// - timer2 match sets; write zero clears
// - received byte sets full; armed read clears
// - async frame error or overrun sets error flag
// - async parity error sets fault; only serial b arms
// - serial flags other than parity fault mirrored in both serial statuses
`timescale 1ns/100ps
`include "psf_map.svh"

module psf_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq,
	input  wire logic        strobe_in_pin,
	input  wire logic        capture_in_pin,
	input  wire logic        tx_load,
	input  wire logic        tx_shift_empty,
	input  wire logic        rx_xfer,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_stop_zero,
	input  wire logic        rx_parity_bad,
	output logic      [7:0]  tx_data,
	output logic             tx_send,
	output logic      [7:0]  port_data
);

	psf_pkg::psf_state_s s_r;
	psf_pkg::psf_state_s s_nxt;

	logic [1:0] pin_rise;
	logic [1:0] pin_fall;

	// ****************************************
	// pin synchronisers
	// ****************************************
	psf_pin_sync u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin     ({capture_in_pin, strobe_in_pin}),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// ****************************************
	// decode helpers
	// ****************************************

	// serial flags as they sit in the top bits of either serial status
	function automatic logic [7:0] ser_bits(input logic [9:0] f);
		logic [7:0] b;
		b                = `PSF_ZERO8;
		b[`PSF_B_HI]     = f[`PSF_F_RXF];
		b[`PSF_B_MID]    = f[`PSF_F_RX_OVERRUN_OR_FRAME_ERR];
		b[`PSF_B_LO]     = f[`PSF_F_TXE];
		return b;
	endfunction

	// flag mask of a single flag index
	function automatic logic [9:0] fbit(input int idx);
		logic [9:0] m;
		m      = '0;
		m[idx] = 1'b1;
		return m;
	endfunction

	// flags that a serial status read may arm; both serial statuses share them
	function automatic logic [9:0] ser_mask();
		logic [9:0] m;
		m = fbit(`PSF_F_TXE) | fbit(`PSF_F_RXF) | fbit(`PSF_F_RX_OVERRUN_OR_FRAME_ERR);
		return m;
	endfunction

	// flags that a receive hold read may clear once armed
	function automatic logic [9:0] rx_mask();
		logic [9:0] m;
		m = fbit(`PSF_F_RXF) | fbit(`PSF_F_RX_OVERRUN_OR_FRAME_ERR) | fbit(`PSF_F_PER);
		return m;
	endfunction

	// ****************************************
	// next-state logic
	// ****************************************
	// bus strobes, decoded addresses and per-cycle flag masks
	logic        rd_now;
	logic        wr_now;
	logic [7:0]  ra;
	logic [7:0]  wa;
	logic [7:0]  wd;
	logic [9:0]  ev;
	logic [9:0]  rdarm;
	logic [9:0]  clr;
	logic [31:0] rv;
	logic [15:0] ocw1;
	logic [15:0] ocw2;

	always_comb begin
		// defaults: hold state, no events, no arming, no clears
		s_nxt  = s_r;
		ev     = '0;
		rdarm  = '0;
		clr    = '0;
		rv     = `PSF_ZERO32;
		ra     = haddr[7:0];
		wa     = s_r.ap_addr;
		wd     = hwdata[7:0];
		ocw1   = s_r.compare1_reg;
		ocw2   = s_r.compare2_reg;
		rd_now = hsel & hready & htrans[1] & ~hwrite;
		wr_now = s_r.ap_wr;

		// address phase capture; the slave never waits
		s_nxt.ap_wr   = hsel & hready & htrans[1] & hwrite;
		s_nxt.ap_rd   = rd_now;
		s_nxt.ap_addr = ra;
		s_nxt.ready   = 1'b1;

		// ****************************************
		// read decode, taken at the address phase
		// ****************************************
		// clear-on-read side effects act at this same edge
		if (rd_now) begin
			unique case (ra)
				`PSF_A_SER_A: begin
					rv[7:0] = ser_bits(s_r.flag);
					rv[`PSF_B_TXEN]  = s_r.tx_en;
					rv[`PSF_B_ASYNC] = s_r.async_md;
					rdarm = ser_mask();
				end
				`PSF_A_SER_B: begin
					rv[7:0] = ser_bits(s_r.flag);
					rv[`PSF_B_PER]   = s_r.flag[`PSF_F_PER];
					rv[`PSF_B_PARON] = s_r.par_on;
					rdarm = ser_mask() | fbit(`PSF_F_PER);
				end
				`PSF_A_TXHOLD: rv[7:0] = s_r.txd;
				`PSF_A_RXHOLD: begin
					rv[7:0] = s_r.rxd;
					clr = s_r.arm & rx_mask();
				end
				`PSF_A_P6CS: begin
					rv[`PSF_B_HI] = s_r.flag[`PSF_F_STB];
					rdarm = fbit(`PSF_F_STB);
				end
				`PSF_A_P6DAT: begin
					rv[7:0] = s_r.pdat;
					clr = s_r.arm & fbit(`PSF_F_STB);
				end
				`PSF_A_T1_A: begin
					rv[`PSF_B_HI]   = s_r.flag[`PSF_F_CAP];
					rv[`PSF_B_MID]  = s_r.flag[`PSF_F_CMP1];
					rv[`PSF_B_LO]   = s_r.flag[`PSF_F_WRAP];
					rv[`PSF_B_EDGE] = s_r.edge_sel;
					rdarm = fbit(`PSF_F_CAP) | fbit(`PSF_F_CMP1) | fbit(`PSF_F_WRAP);
				end
				`PSF_A_T1_B: begin
					rv[`PSF_B_HI]  = s_r.flag[`PSF_F_CAP];
					rv[`PSF_B_MID] = s_r.flag[`PSF_F_CMP1];
					rv[`PSF_B_LO]  = s_r.flag[`PSF_F_CMP2];
					rdarm = fbit(`PSF_F_CAP) | fbit(`PSF_F_CMP1) | fbit(`PSF_F_CMP2);
				end
				`PSF_A_FRC_HI: begin
					rv[7:0] = s_r.free_counter[15:8];
					clr = s_r.arm & fbit(`PSF_F_WRAP);
				end
				`PSF_A_FRC_LO: rv[7:0] = s_r.free_counter[7:0];
				`PSF_A_ICR_HI: begin
					rv[7:0] = s_r.capture_reg[15:8];
					clr = s_r.arm & fbit(`PSF_F_CAP);
				end
				`PSF_A_ICR_LO: rv[7:0] = s_r.capture_reg[7:0];
				`PSF_A_OC1_HI: rv[7:0] = s_r.compare1_reg[15:8];
				`PSF_A_OC1_LO: rv[7:0] = s_r.compare1_reg[7:0];
				`PSF_A_OC2_HI: rv[7:0] = s_r.compare2_reg[15:8];
				`PSF_A_OC2_LO: rv[7:0] = s_r.compare2_reg[7:0];
				`PSF_A_T2CS:   rv[`PSF_B_HI] = s_r.flag[`PSF_F_T2M];
				`PSF_A_T2CON:  rv[7:0] = s_r.t2con;
				`PSF_A_IRQ_ST: rv[9:0] = s_r.sts;
				`PSF_A_IRQ_EN: rv[9:0] = s_r.en;
				default:       rv = `PSF_ZERO32;
			endcase
		end
		s_nxt.rdata = rv;

		// ****************************************
		// write decode, taken at the data phase
		// ****************************************
		// clears below only reach flags armed by a status read, except the timer 2 match clear
		if (wr_now) begin
			unique case (wa)
				`PSF_A_SER_A: begin
					// sync mode drop of enable with data pending locks the path
					if (!s_r.async_md && s_r.tx_en && !wd[`PSF_B_TXEN]
						&& !s_r.flag[`PSF_F_TXE]) begin
						s_nxt.stuck = 1'b1;
					end
					s_nxt.tx_en    = wd[`PSF_B_TXEN];
					s_nxt.async_md = wd[`PSF_B_ASYNC];
				end
				`PSF_A_SER_B: s_nxt.par_on = wd[`PSF_B_PARON];
				`PSF_A_TXHOLD: begin
					s_nxt.txd = wd;
					clr = clr | (s_r.arm & fbit(`PSF_F_TXE));
					if (s_r.tx_en && !s_r.stuck) begin
						s_nxt.pend = 1'b1;
					end
				end
				`PSF_A_P6DAT: begin
					s_nxt.pdat = wd;
					clr = clr | (s_r.arm & fbit(`PSF_F_STB));
				end
				`PSF_A_T1_A: s_nxt.edge_sel = wd[`PSF_B_EDGE];
				`PSF_A_OC1_HI: begin
					ocw1[15:8] = wd;
					clr = clr | (s_r.arm & fbit(`PSF_F_CMP1));
				end
				`PSF_A_OC1_LO: begin
					ocw1[7:0] = wd;
					clr = clr | (s_r.arm & fbit(`PSF_F_CMP1));
				end
				`PSF_A_OC2_HI: begin
					ocw2[15:8] = wd;
					clr = clr | (s_r.arm & fbit(`PSF_F_CMP2));
				end
				`PSF_A_OC2_LO: begin
					ocw2[7:0] = wd;
					clr = clr | (s_r.arm & fbit(`PSF_F_CMP2));
				end
				`PSF_A_T2CS: begin
					if (!wd[`PSF_B_HI] && s_r.flag[`PSF_F_T2M]) begin
						clr = clr | fbit(`PSF_F_T2M);
					end
				end
				`PSF_A_T2CON:   s_nxt.t2con = wd;
				`PSF_A_IRQ_CLR: s_nxt.sts = s_r.sts & ~hwdata[9:0];
				`PSF_A_IRQ_EN:  s_nxt.en = hwdata[9:0];
				default: ;
			endcase
		end
		// compare registers take whichever byte was written above
		s_nxt.compare1_reg = ocw1;
		s_nxt.compare2_reg = ocw2;

		// ****************************************
		// event sources
		// ****************************************
		// transmit side events; a lock holds off the shifter-empty set until reset
		if (tx_load) begin
			s_nxt.pend = 1'b0;
		end
		ev[`PSF_F_TXE] = s_r.async_md ? tx_load
			: (tx_shift_empty & ~s_r.stuck);

		// receive side events, errors only in asynchronous mode
		// an overrun keeps the newer byte in the hold register
		if (rx_xfer) begin
			s_nxt.rxd = rx_byte;
		end
		ev[`PSF_F_RXF]  = rx_xfer;
		ev[`PSF_F_RX_OVERRUN_OR_FRAME_ERR] = s_r.async_md & (rx_stop_zero
			| (rx_xfer & s_r.flag[`PSF_F_RXF]));
		ev[`PSF_F_PER]  = s_r.async_md & s_r.par_on & rx_parity_bad;

		// handshake strobe and input capture
		// pin edges reach here two cycles after the pin moves
		ev[`PSF_F_STB] = pin_fall[0];
		ev[`PSF_F_CAP] = s_r.edge_sel ? pin_rise[1] : pin_fall[1];
		if (ev[`PSF_F_CAP]) begin
			s_nxt.capture_reg = s_r.free_counter;
		end

		// free counter, compares and the wrap flag one cycle after the top
		s_nxt.free_counter       = s_r.free_counter + `PSF_ONE16;
		s_nxt.wrap_pend = (s_r.free_counter == `PSF_FRC_TOP);
		ev[`PSF_F_WRAP] = s_r.wrap_pend;
		ev[`PSF_F_CMP1] = (s_r.compare1_reg == s_r.free_counter);
		ev[`PSF_F_CMP2] = (s_r.compare2_reg == s_r.free_counter);

		// reloadable timer 2
		if (s_r.t2_up_count == s_r.t2con) begin
			ev[`PSF_F_T2M] = 1'b1;
			s_nxt.t2_up_count    = `PSF_ZERO8;
		end else begin
			s_nxt.t2_up_count = s_r.t2_up_count + `PSF_ONE8;
		end

		// ****************************************
		// flag update
		// ****************************************
		// flags: set wins over clear; arms only track flags seen as 1
		s_nxt.flag = (s_r.flag & ~clr) | ev;
		s_nxt.arm  = (s_r.arm & ~clr) | (rdarm & s_r.flag);

		// sticky interrupt status, set wins over a clear write
		// the level output lags the status by one cycle
		s_nxt.sts  = s_nxt.sts | ev;
		s_nxt.irq  = |(s_r.sts & s_r.en);
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r      <= '0;
			s_r.flag <= `PSF_FLAG_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// bus side, all straight from the state register
	assign hrdata    = s_r.rdata;
	assign hreadyout = s_r.ready;
	assign hresp     = 1'b0 & s_r.ready;
	assign irq       = s_r.irq;

	// far side of the serial shifter and the handshake port
	assign tx_data   = s_r.txd;
	assign tx_send   = s_r.pend;
	assign port_data = s_r.pdat;

endmodule

// ---- core/psf_map.svh ----
// register offsets, bit positions and reset values of the status flag bank
`ifndef PSF_MAP_SVH
`define PSF_MAP_SVH

// ****************************************
// register byte offsets (address bits 7:0)
// ****************************************
`define PSF_A_SER_A   8'h00
`define PSF_A_SER_B   8'h04
`define PSF_A_TXHOLD  8'h08
`define PSF_A_RXHOLD  8'h0c
`define PSF_A_P6CS    8'h10
`define PSF_A_P6DAT   8'h14
`define PSF_A_T1_A    8'h18
`define PSF_A_T1_B    8'h1c
`define PSF_A_FRC_HI  8'h20
`define PSF_A_FRC_LO  8'h24
`define PSF_A_ICR_HI  8'h28
`define PSF_A_ICR_LO  8'h2c
`define PSF_A_OC1_HI  8'h30
`define PSF_A_OC1_LO  8'h34
`define PSF_A_OC2_HI  8'h38
`define PSF_A_OC2_LO  8'h3c
`define PSF_A_T2CS    8'h40
`define PSF_A_T2CON   8'h44
`define PSF_A_IRQ_ST  8'h48
`define PSF_A_IRQ_CLR 8'h4c
`define PSF_A_IRQ_EN  8'h50

// ****************************************
// flag indices in the flag vector
// ****************************************
`define PSF_F_TXE  0
`define PSF_F_RXF  1
`define PSF_F_RX_OVERRUN_OR_FRAME_ERR 2
`define PSF_F_PER  3
`define PSF_F_STB  4
`define PSF_F_CAP  5
`define PSF_F_CMP1 6
`define PSF_F_CMP2 7
`define PSF_F_WRAP 8
`define PSF_F_T2M  9
`define PSF_NFLAG  10

// ****************************************
// bit positions inside status registers
// ****************************************
`define PSF_B_HI    7
`define PSF_B_MID   6
`define PSF_B_LO    5
`define PSF_B_PER   4
`define PSF_B_PARON 2
`define PSF_B_TXEN  1
`define PSF_B_ASYNC 0
`define PSF_B_EDGE  1

// ****************************************
// reset values and constants
// ****************************************
`define PSF_FLAG_RST 10'h001
`define PSF_ZERO8    8'h00
`define PSF_ZERO16   16'h0000
`define PSF_ZERO32   32'h0000_0000
`define PSF_ONE16    16'h0001
`define PSF_ONE8     8'h01
`define PSF_FRC_TOP  16'hffff

`endif

// ---- core/psf_pkg.sv ----
// types shared by the status flag bank files
package psf_pkg;

	// state of the pin synchroniser
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
	} psf_sync_s;

	// state of the flag bank
	typedef struct packed {
		logic        ap_rd;
		logic        ap_wr;
		logic [7:0]  ap_addr;
		logic [31:0] rdata;
		logic        ready;
		logic        irq;
		logic [9:0]  flag;
		logic [9:0]  arm;
		logic [9:0]  sts;
		logic [9:0]  en;
		logic        async_md;
		logic        tx_en;
		logic        par_on;
		logic        edge_sel;
		logic        stuck;
		logic        pend;
		logic [7:0]  txd;
		logic [7:0]  rxd;
		logic [7:0]  pdat;
		logic [7:0]  t2_up_count;
		logic [7:0]  t2con;
		logic [15:0] free_counter;
		logic [15:0] capture_reg;
		logic [15:0] compare1_reg;
		logic [15:0] compare2_reg;
		logic        wrap_pend;
	} psf_state_s;

endpackage

// ---- core/psf_pin_sync.sv ----
// two-stage synchroniser with edge detect for the strobe and capture pins
`timescale 1ns/100ps
`include "psf_map.svh"

module psf_pin_sync (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [1:0] pin,
	output logic      [1:0] rise,
	output logic      [1:0] fall
);

	psf_pkg::psf_sync_s s_r;
	psf_pkg::psf_sync_s s_nxt;

	// ****************************************
	// synchroniser chain
	// ****************************************
	// s1 only feeds s2; edges are taken between s2 and s3
	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = pin;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// one-cycle edge pulses
	assign rise = s_r.s2 & ~s_r.s3;
	assign fall = ~s_r.s2 & s_r.s3;

endmodule

// ---- testbench/psf_props.sv ----
// assertion checker for the status flag bank ports
`timescale 1ns/100ps
`include "psf_map.svh"
module psf_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        tx_load,
	input wire logic        tx_shift_empty,
	input wire logic        rx_xfer,
	input wire logic        rx_stop_zero,
	input wire logic        tx_send,
	input wire logic [7:0]  port_data
);
	default clocking dc @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// address phases taken and serial events that may move flags
	wire       go = hsel && hready && htrans[1];
	wire       rd = go && !hwrite;
	wire       wr = go && hwrite;
	wire       ev = tx_load || tx_shift_empty || rx_xfer || rx_stop_zero;
	wire [7:0] a  = haddr[7:0];
	logic      txw;
	// marks the data phase of a transmit hold write
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			txw <= 1'b0;
		else
			txw <= wr && a == `PSF_A_TXHOLD;
	// two counter reads, serial a then b, and a port write
	sequence s_lo2;
		rd && a == `PSF_A_FRC_LO ##2 rd && a == `PSF_A_FRC_LO;
	endsequence
	sequence s_ab;
		rd && a == `PSF_A_SER_A && !ev ##1 !ev ##1 rd && a == `PSF_A_SER_B;
	endsequence
	sequence s_pw;
		wr && a == `PSF_A_P6DAT ##1 1'b1;
	endsequence
	a_resp_okay:
		assert property (hresp == 1'b0) else $error("response not okay");
	a_ready_high:
		assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
	a_rdata_idle:
		assert property (!rd |=> hrdata == 32'h0000_0000) else $error("stray read data");
	a_send_hold:
		assert property (tx_send && !tx_load |=> tx_send) else $error("send dropped early");
	a_send_cause:
		assert property ($rose(tx_send) |-> $past(txw)) else $error("send without write");
	a_port_write:
		assert property (s_pw |=> port_data == $past(hwdata[7:0])) else $error("port not written");
	a_count_step:
		assert property (s_lo2 |=> hrdata[7:0] - $past(hrdata[7:0], 2) == 8'h02)
			else $error("counter step wrong");
	a_flag_mirror:
		assert property (s_ab |=> hrdata[7:5] == $past(hrdata[7:5], 2))
			else $error("serial flags differ");
endmodule

bind psf_top psf_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .hreadyout, .hresp, .tx_load, .tx_shift_empty, .rx_xfer,
	.rx_stop_zero, .tx_send, .port_data);

// ---- testbench/psf_shifter.sv ----
// transmit shifter model: loads held data, then drains it
`timescale 1ns/100ps
module psf_shifter (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       tx_send,
	input  wire logic [4:0] dly,
	output logic            tx_load,
	output logic            tx_shift_empty
);
	logic [5:0] cnt;
	// load pulse dly cycles after a request, empty pulse dly later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 6'h00;
			tx_load <= 1'b0;
			tx_shift_empty <= 1'b0;
		end else begin
			tx_load <= cnt != 6'h00 && cnt == {1'b0, dly};
			tx_shift_empty <= cnt != 6'h00 && cnt == {dly, 1'b0};
			if (cnt == {dly, 1'b0})
				cnt <= 6'h00;
			else if (cnt != 6'h00 || tx_send)
				cnt <= cnt + 6'h01;
		end
	end
endmodule

// ---- testbench/psf_top_test.sv ----
// self-checking bench for the status flag bank
`timescale 1ns/100ps
`include "psf_map.svh"
module psf_top_test;
	typedef struct {string nm; logic [15:0] e; logic [15:0] m;} psf_note_s;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dp = 0;
	logic        stb = 1, cap = 0, rxx = 0, sz = 0, pb = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0]  htrans = '0;
	logic [7:0]  rxb = '0, d = '0, tx_data, port_data;
	logic [4:0]  dly = 5'h03;
	logic        hreadyout, hresp, irq, tx_load, tx_se, tx_send;
	int          failures = 0, num_checks = 0;
	psf_note_s   q[$], n;
	always #10 hclk = ~hclk;
	psf_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .strobe_in_pin(stb),
		.capture_in_pin(cap), .tx_load, .tx_shift_empty(tx_se), .rx_xfer(rxx),
		.rx_byte(rxb), .rx_stop_zero(sz), .rx_parity_bad(pb), .tx_data, .tx_send, .port_data);
	psf_shifter u_far (.hclk, .hresetn, .tx_send, .dly, .tx_load, .tx_shift_empty(tx_se));
	task chk(input string nm, input logic [15:0] s, e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one single transfer; entered just after a clock edge
	task xf(input logic w, input logic [7:0] a, input logic [15:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, wd};
		do @(posedge hclk); while (!hreadyout);
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e, m);
		q.push_back('{$sformatf("reg %h", a), e, m});
		xf(1'b0, a, 16'h0000);
	endtask
	task cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task rx(input logic [7:0] b, input logic p, s);
		rxx <= 1'b1;
		rxb <= b;
		pb <= p;
		sz <= s;
		cyc(1);
		rxx <= 1'b0;
		pb <= 1'b0;
		sz <= 1'b0;
		cyc(1);
	endtask
	// compares each read data phase with the oldest note
	always @(posedge hclk) begin
		if (dp && hreadyout && q.size() > 0) begin
			n = q.pop_front();
			chk(n.nm, hrdata[15:0] & n.m, n.e);
		end
		dp <= hsel && htrans[1] && !hwrite && hreadyout;
	end
	initial begin
		#(80000 * 20);
		failures++;
		print_verdict;
	end
	initial begin
		void'($urandom(32'h6d66));
		cyc(5);
		hresetn <= 1'b1;
		cyc(1);
		rd(`PSF_A_SER_A, 16'h0020, 16'h00e0);
		rd(`PSF_A_SER_B, 16'h0020, 16'h00f0);
		rd(`PSF_A_FRC_LO, 16'h0000, 16'h0000);
		rd(`PSF_A_FRC_LO, 16'h0000, 16'h0000);
		rd(8'hfc, 16'h0000, 16'hffff);
		rd(`PSF_A_T1_A, 16'h0040, 16'h0040);
		xf(1'b1, `PSF_A_OC2_HI, 16'h0080);
		rd(`PSF_A_T1_B, 16'h0020, 16'h0020);
		xf(1'b1, `PSF_A_OC2_LO, 16'h0000);
		xf(1'b1, `PSF_A_OC1_HI, 16'h0080);
		rd(`PSF_A_T1_B, 16'h0000, 16'h0060);
		xf(1'b1, `PSF_A_T1_A, 16'h0002);
		cap <= 1'b1;
		cyc(6);
		rd(`PSF_A_T1_A, 16'h0080, 16'h0080);
		rd(`PSF_A_ICR_HI, 16'h0000, 16'h00ff);
		rd(`PSF_A_T1_A, 16'h0000, 16'h0080);
		stb <= 1'b0;
		cyc(6);
		rd(`PSF_A_P6CS, 16'h0080, 16'h0080);
		d = 8'($urandom);
		xf(1'b1, `PSF_A_P6DAT, {8'h00, d});
		cyc(1);
		chk("port_data", {8'h00, port_data}, {8'h00, d});
		rd(`PSF_A_P6CS, 16'h0000, 16'h0080);
		xf(1'b1, `PSF_A_T2CON, 16'h00ff);
		rd(`PSF_A_T2CS, 16'h0080, 16'h0080);
		xf(1'b1, `PSF_A_T2CS, 16'h0000);
		rd(`PSF_A_T2CS, 16'h0000, 16'h0080);
		xf(1'b1, `PSF_A_IRQ_CLR, 16'h03ff);
		xf(1'b1, `PSF_A_IRQ_EN, 16'h0200);
		cyc(260);
		chk("irq", {15'h0000, irq}, 16'h0001);
		xf(1'b1, `PSF_A_IRQ_EN, 16'h0000);
		cyc(2);
		chk("irq", {15'h0000, irq}, 16'h0000);
		rd(`PSF_A_IRQ_ST, 16'h0200, 16'h0200);
		xf(1'b1, `PSF_A_IRQ_CLR, 16'h0200);
		xf(1'b1, `PSF_A_IRQ_EN, 16'h0200);
		cyc(2);
		chk("irq", {15'h0000, irq}, 16'h0000);
		$display("timer and port tests done");
		dly <= 5'h08;
		xf(1'b1, `PSF_A_SER_A, 16'h0003);
		rd(`PSF_A_SER_A, 16'h0020, 16'h0020);
		xf(1'b1, `PSF_A_TXHOLD, {8'h00, d});
		cyc(1);
		chk("tx_data", {8'h00, tx_data}, {8'h00, d});
		rd(`PSF_A_SER_A, 16'h0000, 16'h0020);
		cyc(20);
		xf(1'b1, `PSF_A_TXHOLD, {8'h00, d});
		rd(`PSF_A_SER_A, 16'h0020, 16'h0020);
		xf(1'b1, `PSF_A_SER_B, 16'h0004);
		rx(d, 1'b1, 1'b0);
		rd(`PSF_A_SER_A, 16'h0080, 16'h00c0);
		rd(`PSF_A_RXHOLD, {8'h00, d}, 16'h00ff);
		rd(`PSF_A_SER_B, 16'h0010, 16'h00d0);
		rd(`PSF_A_RXHOLD, {8'h00, d}, 16'h00ff);
		rd(`PSF_A_SER_B, 16'h0000, 16'h00d0);
		rx(d, 1'b0, 1'b0);
		rx(~d, 1'b0, 1'b0);
		rd(`PSF_A_SER_B, 16'h00c0, 16'h00c0);
		rd(`PSF_A_RXHOLD, {8'h00, ~d}, 16'h00ff);
		rd(`PSF_A_SER_B, 16'h0000, 16'h00c0);
		rx(d, 1'b0, 1'b1);
		rd(`PSF_A_SER_A, 16'h00c0, 16'h00c0);
		$display("serial tests done");
		cyc(65536);
		rd(`PSF_A_T1_A, 16'h0020, 16'h0020);
		rd(`PSF_A_FRC_HI, 16'h0000, 16'h0000);
		rd(`PSF_A_T1_A, 16'h0000, 16'h0020);
		dly <= 5'h0c;
		xf(1'b1, `PSF_A_SER_A, 16'h0002);
		rd(`PSF_A_SER_A, 16'h0020, 16'h0020);
		xf(1'b1, `PSF_A_TXHOLD, {8'h00, d});
		xf(1'b1, `PSF_A_SER_A, 16'h0000);
		cyc(30);
		rd(`PSF_A_SER_A, 16'h0000, 16'h0020);
		xf(1'b1, `PSF_A_SER_A, 16'h0002);
		xf(1'b1, `PSF_A_TXHOLD, {8'h00, d});
		cyc(2);
		chk("tx_send", {15'h0000, tx_send}, 16'h0000);
		hresetn <= 1'b0;
		cyc(2);
		hresetn <= 1'b1;
		cyc(1);
		rd(`PSF_A_SER_A, 16'h0020, 16'h0020);
		cyc(2);
		$display("wrap and lock tests done");
		print_verdict;
	end
endmodule
